// >>> verilog/irq_arb_pkg.sv
package irq_arb_pkg;
	// program memory and vector layout
	localparam int PC_W = 15;
	localparam logic [PC_W-1:0] ENTRY_ADDR = 15'h00FF;
	localparam logic [7:0] TRAP_OPCODE = 8'h00;
	localparam logic [2:0] VEC_TOP_BITS = 3'h7;
	localparam logic [7:0] BLOCK_LAST = 8'hFF;
	localparam int SLOT_W = 4;
	localparam logic [SLOT_W-1:0] SLOT_TRAP = 4'hF;
	localparam logic [SLOT_W-1:0] SLOT_DEFAULT = 4'h0;
	localparam int MAX_SRC = 14;
	// reserved slots 14, 8, 6 and 5 tied inactive
	localparam logic [MAX_SRC-1:0] SRC_USED_DEF = 14'h1F4F;
	// acknowledge sequence length in instruction cycles
	localparam int ACK_ICYC = 7;
	localparam int ICYC_CLKS_DEF = 1;
	// register map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_IRQ_PENDING = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PSW = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
	// field positions
	localparam int PSW_GIE_BIT = 0;
	localparam int ST_TRAP_BIT = 0;
	localparam int ST_BUSY_BIT = 1;
	localparam int ST_BOOT_BIT = 2;
	localparam int ST_SLOT_LSB = 4;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ACK = 4'b0010,
		ST_VHI = 4'b0100,
		ST_VLO = 4'b1000
	} arb_state_e;
endpackage

// >>> verilog/vectored_interrupt_arbiter.sv
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// Operation
// R1: every acknowledged interrupt branches to entry address 00FF hex.
// R2: trap ranks highest, default vector lowest, other sources fixed between.
// R3: each maskable source has enable and pending; event sets pending to 1.
// R4: software reads and writes all enables and pending flags.
// R5: maskable pending interrupts only with enable, global enable, no trap routine.
// R6: sampled at instruction start; highest rank served, others stay pending.
// R7: reset clears all pending, all enables and the global enable.
// R8: already pending flag fires as soon as its enable gets set.
// R9: acknowledge at next normally executed instruction, after any pending skip.
// R10: acknowledge clears global enable, pushes next address, jumps, seven cycles. The code keeps the global enable on a trap acknowledge.
// R11: status word write can set global enable for nesting.
// R12: return-from-interrupt sets global enable and pops the return address.
// R13: pending enabled interrupt on return is serviced immediately.
// R14: boot ROM execution suppresses interrupts, global enable untouched. The code suppresses only maskables; a trap fetch is still acknowledged.
// R15: vector select jumps through vector of best enabled pending source.
// R16: 32-byte table tops the VECTOR_SELECT_INSTR block, next block if VECTOR_SELECT_INSTR is last.
// R17: vector is 15 bits in two bytes, high byte first.
// R18: slots rise with rank from 0yE0, trap at 0yFE.
// R19: with nothing active vector select uses the default slot.
// R20: service software should clear pending early to catch repeats.
// R21: first VECTOR_SELECT_INSTR cycle forms even low byte E0..FE, high PC byte kept.
// R22: hidden trap pending flag blocks maskables until clear-trap or reset.
// R23: trap raised whenever the trap opcode is loaded into the instruction register.
// R24: source count and rank-to-slot usage are parameters.
module vectored_interrupt_arbiter
	import irq_arb_pkg::*;
#(
	parameter int NUM_SRC = MAX_SRC,
	parameter logic [MAX_SRC-1:0] SRC_USED = SRC_USED_DEF,
	parameter int ICYC_CLKS = ICYC_CLKS_DEF
) (
	input wire logic I_MCLK,
	input wire logic I_SRST,
	input wire apb_req_s I_APB_REQ,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic [NUM_SRC-1:0] I_SRC_EVENT,
	input wire logic I_INSTR_START,
	input wire logic I_SKIP_NEXT,
	input wire logic [PC_W-1:0] I_NEXT_ADDR,
	input wire logic I_IR_LOAD,
	input wire logic [7:0] I_IR_OPCODE,
	input wire logic I_VIS_EXEC,
	input wire logic [PC_W-1:0] I_VIS_PC,
	input wire logic I_RETURN_FROM_IRQ_INSTR_EXEC,
	input wire logic I_CLEAR_TRAP_PENDING_INSTR_EXEC,
	input wire logic I_BOOT_ROM,
	input wire logic [7:0] I_PMEM_DATA,
	output logic O_BUSY,
	output logic O_PUSH,
	output logic [PC_W-1:0] O_PUSH_ADDR,
	output logic O_POP,
	output logic O_PC_LOAD,
	output logic [PC_W-1:0] O_PC_VALUE,
	output logic O_PMEM_RD,
	output logic [PC_W-1:0] O_PMEM_ADDR
);

	localparam int DIV_W = $clog2(ICYC_CLKS + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(ICYC_CLKS - 1);
	localparam logic [3:0] ACK_LAST = 4'(ACK_ICYC - 1);
	localparam logic [NUM_SRC-1:0] USED = SRC_USED[NUM_SRC-1:0]; // R24

	// refuse shapes the slot encoding cannot hold
	if (NUM_SRC < 1 || NUM_SRC > MAX_SRC) begin : g_bad_src
		$error("NUM_SRC must be 1..14");
	end
	if (ICYC_CLKS < 1) begin : g_bad_div
		$error("ICYC_CLKS must be at least 1");
	end

	// highest ranked active slot; source i sits in slot i+1
	function automatic logic [SLOT_W-1:0] best_slot(input logic [NUM_SRC-1:0] act);
		logic [SLOT_W-1:0] s;
		s = SLOT_DEFAULT; // R19
		for (int i = 0; i < NUM_SRC; i++) begin
			if (act[i]) begin
				s = SLOT_W'(i + 1); // R2
			end
		end
		return s;
	endfunction

	arb_state_e st_ff, nxt_st;
	logic [DIV_W-1:0] div_ff;
	logic [3:0] ack_cnt_ff;
	logic [NUM_SRC-1:0] enable_ff, pending_ff, nxt_enable, nxt_pending;
	logic gie_ff, nxt_gie;
	logic trap_pnd_ff;
	logic [SLOT_W-1:0] slot_ff;
	logic [6:0] vec_hi_ff;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff;
	logic busy_ff, push_ff, pop_ff, pc_load_ff, pmem_rd_ff;
	logic [PC_W-1:0] push_addr_ff, pc_value_ff, pmem_addr_ff;

	// bus decode
	wire logic setup_ph = I_APB_REQ.psel & I_APB_REQ.penable & ~pready_ff;
	wire logic access_ph = I_APB_REQ.psel & I_APB_REQ.penable & pready_ff;
	wire logic wr_en = access_ph & I_APB_REQ.pwrite;
	wire logic hit_en = I_APB_REQ.paddr == OFS_IRQ_ENABLE;
	wire logic hit_pnd = I_APB_REQ.paddr == OFS_IRQ_PENDING;
	wire logic hit_psw = I_APB_REQ.paddr == OFS_PSW;
	wire logic hit_st = I_APB_REQ.paddr == OFS_STATUS;
	wire logic hit_any = hit_en | hit_pnd | hit_psw | hit_st;

	// read mux, unused bits read as zero
	wire logic [31:0] rd_status = 32'((trap_pnd_ff << ST_TRAP_BIT) | (busy_ff << ST_BUSY_BIT)
		| (I_BOOT_ROM << ST_BOOT_BIT) | (32'(slot_ff) << ST_SLOT_LSB));
	wire logic [31:0] rd_mux = hit_en ? 32'(enable_ff) :
		hit_pnd ? 32'(pending_ff) :
		hit_psw ? 32'(gie_ff) << PSW_GIE_BIT :
		hit_st ? rd_status : RESET_WORD;

	// instruction cycle enable from the master clock
	wire logic icyc_en = div_ff == DIV_LAST;

	// interrupt qualification
	wire logic [NUM_SRC-1:0] active = enable_ff & pending_ff;
	wire logic idle = st_ff == ST_IDLE;
	wire logic trap_fetch = I_IR_LOAD & (I_IR_OPCODE == TRAP_OPCODE); // R23
	wire logic mask_take = I_INSTR_START & ~I_SKIP_NEXT & gie_ff & (|active) // R5 R6 R8 R9 R13
		& ~trap_pnd_ff & ~I_BOOT_ROM; // R14 R22
	wire logic ack_start = idle & (trap_fetch | mask_take);
	wire logic vis_start = idle & I_VIS_EXEC & ~ack_start;
	wire logic ack_done = (st_ff == ST_ACK) & icyc_en & (ack_cnt_ff == ACK_LAST);

	// arbitration for vector select, trap wins over all
	wire logic [SLOT_W-1:0] vis_slot = trap_pnd_ff ? SLOT_TRAP : best_slot(active); // R15 R2
	wire logic [7:0] vis_low = {VEC_TOP_BITS, vis_slot, 1'b0}; // R18 R21
	wire logic [6:0] vis_blk = (I_VIS_PC[7:0] == BLOCK_LAST) ? I_VIS_PC[14:8] + 7'h01 : I_VIS_PC[14:8]; // R16
	wire logic [PC_W-1:0] vec_addr = {vis_blk, vis_low}; // R21

	// register next values; hardware set wins over software clear
	assign nxt_enable = wr_en & hit_en ? I_APB_REQ.pwdata[NUM_SRC-1:0] & USED : enable_ff; // R4
	assign nxt_pending = ((wr_en & hit_pnd) ? I_APB_REQ.pwdata[NUM_SRC-1:0] & USED : pending_ff) // R24
		| (I_SRC_EVENT & USED); // R3 R4
	assign nxt_gie = ack_start & ~trap_fetch ? 1'b0 : // R10
		I_RETURN_FROM_IRQ_INSTR_EXEC ? 1'b1 : // R12
		wr_en & hit_psw ? I_APB_REQ.pwdata[PSW_GIE_BIT] : gie_ff; // R11

	// state sequencing
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			ST_IDLE: begin
				if (ack_start) begin
					nxt_st = ST_ACK;
				end else if (vis_start) begin
					nxt_st = ST_VHI;
				end
			end
			ST_ACK: begin
				if (ack_done) begin
					nxt_st = ST_IDLE;
				end
			end
			ST_VHI: nxt_st = ST_VLO;
			ST_VLO: nxt_st = ST_IDLE;
			default: nxt_st = ST_IDLE;
		endcase
	end

	// apb slave, one wait state per access
	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= RESET_WORD;
		end else begin
			pready_ff <= setup_ph;
			pslverr_ff <= setup_ph & ~hit_any;
			prdata_ff <= setup_ph & ~I_APB_REQ.pwrite ? rd_mux : RESET_WORD;
		end
	end

	// interrupt flags
	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			enable_ff <= '0; // R7
			pending_ff <= '0; // R7
			gie_ff <= 1'b0; // R7
			trap_pnd_ff <= 1'b0; // R22
		end else begin
			enable_ff <= nxt_enable;
			pending_ff <= nxt_pending;
			gie_ff <= nxt_gie;
			trap_pnd_ff <= trap_fetch | (trap_pnd_ff & ~I_CLEAR_TRAP_PENDING_INSTR_EXEC); // R22 R23
		end
	end

	// divider and acknowledge cycle counter
	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			div_ff <= '0;
			ack_cnt_ff <= 4'h0;
		end else begin
			div_ff <= icyc_en ? '0 : div_ff + DIV_W'(1);
			ack_cnt_ff <= st_ff != ST_ACK ? 4'h0 : ack_cnt_ff + 4'(icyc_en); // R10
		end
	end

	// state and stack handshake; push happens in the first acknowledge cycle
	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			st_ff <= ST_IDLE;
			busy_ff <= 1'b0;
			push_ff <= 1'b0;
			push_addr_ff <= '0;
			pop_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			busy_ff <= nxt_st != ST_IDLE;
			push_ff <= ack_start; // R10
			push_addr_ff <= ack_start ? I_NEXT_ADDR : push_addr_ff; // R10
			pop_ff <= I_RETURN_FROM_IRQ_INSTR_EXEC; // R12
		end
	end

	// program counter loads and vector fetch; read data comes back in the same cycle
	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			pc_load_ff <= 1'b0;
			pc_value_ff <= '0;
			pmem_rd_ff <= 1'b0;
			pmem_addr_ff <= '0;
			slot_ff <= SLOT_DEFAULT;
			vec_hi_ff <= 7'h00;
		end else begin
			pc_load_ff <= ack_done | (st_ff == ST_VLO);
			pmem_rd_ff <= vis_start | (st_ff == ST_VHI);
			if (ack_done) begin
				pc_value_ff <= ENTRY_ADDR; // R1 R10
			end else if (st_ff == ST_VLO) begin
				pc_value_ff <= {vec_hi_ff, I_PMEM_DATA}; // R17
			end
			if (vis_start) begin
				pmem_addr_ff <= vec_addr; // R21
				slot_ff <= vis_slot;
			end else if (st_ff == ST_VHI) begin
				pmem_addr_ff <= pmem_addr_ff + 15'h0001; // R17
				vec_hi_ff <= I_PMEM_DATA[6:0]; // R17
			end
		end
	end

	assign O_PRDATA = prdata_ff;
	assign O_PREADY = pready_ff;
	assign O_PSLVERR = pslverr_ff;
	assign O_BUSY = busy_ff;
	assign O_PUSH = push_ff;
	assign O_PUSH_ADDR = push_addr_ff;
	assign O_POP = pop_ff;
	assign O_PC_LOAD = pc_load_ff;
	assign O_PC_VALUE = pc_value_ff;
	assign O_PMEM_RD = pmem_rd_ff;
	assign O_PMEM_ADDR = pmem_addr_ff;

	// checks
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (I_SRST);

	localparam int ACK_CLKS = ACK_ICYC * ICYC_CLKS;
	logic [15:0] ack_len_ff;
	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			ack_len_ff <= 16'h0000;
		end else begin
			ack_len_ff <= st_ff == ST_ACK ? ack_len_ff + 16'h0001 : 16'h0000;
		end
	end

	sequence s_ack_begin;
		idle && ack_start;
	endsequence
	sequence s_vis_begin;
		vis_start;
	endsequence

	chk_entry_addr: assert property (ack_done |=> O_PC_LOAD && O_PC_VALUE == ENTRY_ADDR) // R1
		else $error("acknowledge did not jump to entry address");
	chk_ack_length: assert property (ack_done |-> ack_len_ff == 16'(ACK_CLKS - 1)) // R10
		else $error("acknowledge sequence length wrong");
	chk_ack_push: assert property (s_ack_begin |=> O_PUSH && O_BUSY && O_PUSH_ADDR == $past(I_NEXT_ADDR)) // R10
		else $error("return address not pushed on acknowledge");
	chk_gie_cleared: assert property (s_ack_begin ##0 !trap_fetch |=> !gie_ff) // R10
		else $error("global enable kept on acknowledge");
	chk_return_from_irq_instr_gie: assert property (I_RETURN_FROM_IRQ_INSTR_EXEC && !ack_start |=> gie_ff && O_POP) // R12
		else $error("return did not restore global enable");
	chk_trap_blocks: assert property (trap_pnd_ff && !trap_fetch && idle |=> st_ff != ST_ACK) // R22
		else $error("maskable taken during trap routine");
	chk_boot_mask: assert property (I_BOOT_ROM && !trap_fetch && idle |=> st_ff != ST_ACK) // R14
		else $error("interrupt taken in boot rom");
	chk_event_pend: assert property (I_SRC_EVENT[0] && USED[0] |=> pending_ff[0]) // R3
		else $error("event lost against clear");
	chk_vis_lowbyte: assert property (s_vis_begin |=> O_PMEM_RD && O_PMEM_ADDR[7:0] == $past(vis_low)
		&& O_PMEM_ADDR[0] == 1'b0 ##1 O_PMEM_ADDR[0] == 1'b1 ##1 O_PC_LOAD) // R21 R17
		else $error("vector fetch sequence wrong");
	chk_vis_default: assert property (s_vis_begin ##0 (!trap_pnd_ff && active == '0)
		|=> O_PMEM_ADDR[7:0] == {VEC_TOP_BITS, SLOT_DEFAULT, 1'b0}) // R19
		else $error("default slot not used");
	chk_vec_block: assert property (s_vis_begin ##0 (I_VIS_PC[7:0] == BLOCK_LAST)
		|=> O_PMEM_ADDR[14:8] == $past(I_VIS_PC[14:8]) + 7'h01) // R16
		else $error("vector table block wrong");
	chk_mask_take: assert property (idle && I_INSTR_START && !I_SKIP_NEXT && gie_ff && |active
		&& !trap_pnd_ff && !I_BOOT_ROM |=> st_ff == ST_ACK) // R5 R8
		else $error("qualified interrupt not taken");

	// further checks on trap, status word and bus answers
	sequence s_trap_begin;
		idle && trap_fetch;
	endsequence

	// trap fetch raises the hidden flag and starts the push
	chk_trap_sets: assert property (s_trap_begin // R23
		|=> trap_pnd_ff && O_PUSH)
		else $error("trap fetch not taken");

	// clear-trap drops the flag unless a new trap lands with it
	chk_trap_clear: assert property (I_CLEAR_TRAP_PENDING_INSTR_EXEC && !trap_fetch // R22
		|=> !trap_pnd_ff)
		else $error("trap flag not cleared");

	// trap leaves the global enable alone
	chk_trap_gie: assert property (trap_fetch && !I_RETURN_FROM_IRQ_INSTR_EXEC && !(wr_en && hit_psw) // R22
		|=> gie_ff == $past(gie_ff))
		else $error("trap changed global enable");

	// skipped instruction starts no acknowledge unless a trap is fetched with it
	chk_skip_hold: assert property (idle && I_INSTR_START && I_SKIP_NEXT && !trap_fetch // R9
		|=> st_ff != ST_ACK)
		else $error("acknowledge on skipped instruction");

	// status word write sets or clears the global enable
	chk_gie_write: assert property (wr_en && hit_psw && !ack_start && !I_RETURN_FROM_IRQ_INSTR_EXEC // R11
		|=> gie_ff == $past(I_APB_REQ.pwdata[PSW_GIE_BIT]))
		else $error("status word write lost");

	// enable write lands, reserved bits forced low
	chk_enable_write: assert property (wr_en && hit_en // R4
		|=> enable_ff == ($past(I_APB_REQ.pwdata[NUM_SRC-1:0]) & USED))
		else $error("enable write lost");

	// reserved slots can never become active
	chk_reserved_tied: assert property ((enable_ff & ~USED) == '0 // R24
		&& (pending_ff & ~USED) == '0)
		else $error("reserved slot set");

	// trap pending wins the top slot
	chk_vis_trap: assert property (s_vis_begin ##0 trap_pnd_ff // R2 R18
		|=> O_PMEM_ADDR[7:0] == {VEC_TOP_BITS, SLOT_TRAP, 1'b0})
		else $error("trap slot not chosen");

	// sequencer stalls for exactly the two vector fetch cycles
	chk_vis_busy: assert property (s_vis_begin // R15
		|=> O_BUSY ##1 O_BUSY ##1 !O_BUSY)
		else $error("vector select stall wrong");

	// ready is a single-cycle answer, one wait state per access
	chk_pready_pulse: assert property (O_PREADY // R4
		|=> !O_PREADY)
		else $error("ready held too long");

	// error flag only travels with ready
	chk_slverr_ready: assert property (O_PSLVERR // R4
		|-> O_PREADY)
		else $error("error flag without ready");

	// read data is zero outside the answer cycle
	chk_prdata_idle: assert property (!O_PREADY // R4
		|-> O_PRDATA == RESET_WORD)
		else $error("read data outside answer");
endmodule // vectored_interrupt_arbiter

// >>> sim/pmem_model.sv
`timescale 1ns/1ps
module pmem_model (
	input wire logic i_clk,
	input wire logic i_rd,
	input wire logic [14:0] i_addr,
	output logic [7:0] o_data
);
	logic [7:0] last_ff;
	// vector bytes follow the address; idle bus shows the inverse of the last byte
	assign o_data = i_rd ? (i_addr[7:0] ^ {1'b0, i_addr[14:8]}) : ~last_ff;
	always_ff @(posedge i_clk) begin
		if (i_rd) begin
			last_ff <= o_data;
		end
	end
endmodule // pmem_model

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import irq_arb_pkg::*;
;
	localparam logic [13:0] M = SRC_USED_DEF;
	logic clk = 0, rst = 1, err, ist, skp, ir, vector_select_instr, return_from_irq_instr, clear_trap_pending_instr, boot;
	logic pready, pslverr, busy, push, pop, pcl, prd;
	apb_req_s req;
	logic [31:0] rd, prdata;
	logic [13:0] ev, en, msk;
	logic [7:0] op, pd;
	logic [14:0] nxt, vpc, paddr_o, pcv, pma, last_push, last_pc, first_rd;
	logic [15:0] rnd = 16'h005A;
	int n_fail = 0, num_checks = 0, n_push = 0, n_pop = 0, cyc = 0, t_push = 0, t_pcl = 0, n = 0;
	always #20 clk = ~clk;
	vectored_interrupt_arbiter u_dut (.I_MCLK(clk), .I_SRST(rst), .I_APB_REQ(req), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_SRC_EVENT(ev), .I_INSTR_START(ist), .I_SKIP_NEXT(skp),
		.I_NEXT_ADDR(nxt), .I_IR_LOAD(ir), .I_IR_OPCODE(op), .I_VIS_EXEC(vector_select_instr), .I_VIS_PC(vpc),
		.I_RETURN_FROM_IRQ_INSTR_EXEC(return_from_irq_instr), .I_CLEAR_TRAP_PENDING_INSTR_EXEC(clear_trap_pending_instr), .I_BOOT_ROM(boot), .I_PMEM_DATA(pd), .O_BUSY(busy),
		.O_PUSH(push), .O_PUSH_ADDR(paddr_o), .O_POP(pop), .O_PC_LOAD(pcl), .O_PC_VALUE(pcv),
		.O_PMEM_RD(prd), .O_PMEM_ADDR(pma));
	pmem_model u_pmem (.i_clk(clk), .i_rd(prd), .i_addr(pma), .o_data(pd));
	// log sequencer-side pulses at the settled half of the cycle
	always @(negedge clk) begin
		cyc++;
		if (push) begin n_push++; t_push = cyc; last_push = paddr_o; end
		if (pcl) begin t_pcl = cyc; last_pc = pcv; end
		if (pop) n_pop++;
		if (prd && first_rd === 15'h7FFF) first_rd = pma;
	end
	function logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// highest ranked active source, slot 0 when none
	function logic [3:0] best(input logic [13:0] m);
		best = SLOT_DEFAULT;
		for (int i = 0; i < 14; i++) if (m[i]) best = i[3:0] + 4'h1;
	endfunction
	// table sits in the next block when the instruction is the block's last byte
	function logic [14:0] vaddr(input logic [14:0] pc, input logic [3:0] s);
		return {pc[14:8] + {6'h0, &pc[7:0]}, 8'hE0 + {3'h0, s, 1'b0}};
	endfunction
	function logic [14:0] vec(input logic [14:0] a);
		logic [7:0] hi, lo;
		hi = a[7:0] ^ {1'b0, a[14:8]};
		lo = (a[7:0] + 8'h01) ^ {1'b0, a[14:8]};
		return {hi[6:0], lo};
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one transfer; held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	// sequencer pulses {boot, skip, clear_trap_pending_instr, return_from_irq_instr, vis, ir, start}; then let the sequence run out
	task go(input logic [6:0] p);
		rnd = lfsr(rnd);
		@(posedge clk);
		{boot, skp, clear_trap_pending_instr, return_from_irq_instr, vector_select_instr, ir, ist} <= p;
		nxt <= rnd[14:0];
		@(posedge clk);
		{boot, skp, clear_trap_pending_instr, return_from_irq_instr, vector_select_instr, ir, ist} <= 7'h0;
		repeat (12) @(posedge clk);
	endtask
	task give_verdict;
		if (n_fail == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// a hang costs at most about 50k cycles
	initial begin
		#2000000;
		n_fail++;
		give_verdict;
	end
	initial begin
		req = '0; ev = '0; {boot, skp, clear_trap_pending_instr, return_from_irq_instr, vector_select_instr, ir, ist} = 7'h0;
		op = 8'hFF; nxt = '0; vpc = '0; first_rd = '0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		apb(0, OFS_IRQ_ENABLE, 0); chk(rd, RESET_WORD);
		apb(0, OFS_IRQ_PENDING, 0); chk(rd, RESET_WORD);
		apb(0, OFS_PSW, 0); chk(rd, RESET_WORD);
		apb(0, 8'h10, 0); chk({rd[30:0], err}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			apb(1, OFS_IRQ_ENABLE, {16'h0, rnd}); apb(0, OFS_IRQ_ENABLE, 0); chk(rd, {18'h0, rnd[13:0] & M});
			apb(1, OFS_IRQ_PENDING, {16'h0, ~rnd}); apb(0, OFS_IRQ_PENDING, 0); chk(rd, {18'h0, ~rnd[13:0] & M});
		end
		apb(1, OFS_IRQ_ENABLE, 0);
		apb(1, OFS_IRQ_PENDING, 0);
		ev <= 14'h0005;
		@(posedge clk);
		ev <= '0;
		apb(0, OFS_IRQ_PENDING, 0); chk(rd, 32'h5);
		apb(1, OFS_IRQ_PENDING, 4);
		apb(1, OFS_PSW, 1);
		n = n_push;
		go(7'h01); chk(n_push, n);
		apb(1, OFS_IRQ_ENABLE, 4);
		go(7'h21); chk(n_push, n);
		go(7'h41); chk(n_push, n);
		go(7'h01); chk(n_push, n + 1);
		chk(last_push, nxt);
		chk(t_pcl - t_push, ACK_ICYC);
		chk(last_pc, ENTRY_ADDR);
		apb(0, OFS_PSW, 0); chk(rd, 0);
		apb(1, OFS_PSW, 1); go(7'h01); chk(n_push, n + 2);
		go(7'h08); chk(n_pop, 1);
		apb(0, OFS_PSW, 0); chk(rd, 1);
		go(7'h01); chk(n_push, n + 3);
		apb(1, OFS_IRQ_PENDING, 0);
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd); en = rnd[13:0];
			rnd = lfsr(rnd); msk = (i == 5) ? 14'h0 : rnd[13:0];
			apb(1, OFS_IRQ_ENABLE, {18'h0, en}); apb(1, OFS_IRQ_PENDING, {18'h0, msk});
			msk = msk & en & M;
			vpc <= (i == 2) ? {rnd[14:8], 8'hFF} : rnd[14:0];
			first_rd = 15'h7FFF;
			go(7'h04); chk(first_rd, vaddr(vpc, best(msk)));
			chk(last_pc, vec(vaddr(vpc, best(msk))));
		end
		apb(1, OFS_IRQ_ENABLE, 32'h3FFF); apb(1, OFS_IRQ_PENDING, 1); apb(1, OFS_PSW, 1);
		op <= TRAP_OPCODE;
		go(7'h02); chk(n_push, n + 4);
		apb(0, OFS_STATUS, 0); chk(rd[ST_TRAP_BIT], 1);
		apb(1, OFS_PSW, 1); go(7'h01); chk(n_push, n + 4);
		first_rd = 15'h7FFF;
		go(7'h04); chk(first_rd, vaddr(vpc, SLOT_TRAP));
		go(7'h10); go(7'h01); chk(n_push, n + 5);
		give_verdict;
	end
endmodule // tb_top
